// File: brake_search_map.svh
`ifndef BRAKE_SEARCH_MAP_SVH
`define BRAKE_SEARCH_MAP_SVH
// ----------------------------------------------------------------------------
// setting encodings and defaults
// ----------------------------------------------------------------------------
`define STOP_RAMP              2'h0          // ramp-to-stop code
`define STOP_COAST             2'h1          // coast-to-stop code
`define SEARCH_DETECT          1'h0          // current-detection search
`define SEARCH_ESTIMATE        1'h1          // speed-estimation search
`define BRAKE_FREQ_DEFAULT     16'h0005      // 0.5 Hz in 0.1 Hz units
`define BRAKE_FREQ_MAX         16'h0064      // 10.0 Hz in 0.1 Hz units
`define INJ_PCT_DEFAULT        8'h32         // 50 percent
`define INJ_PCT_MAX            8'h4B         // 75 percent
`define INJ_PCT_CARRIER_LIMIT  8'h32         // above 50 percent: low carrier
`define CARRIER_LOW_KHZ        8'h01         // 1 kHz carrier
`define INJ_START_DEFAULT      16'h0032      // 0.50 s in 10 ms units
`define INJ_STOP_DEFAULT       16'h0032      // 0.50 s
`define INJ_TIME_MAX           16'h03E8      // 10.00 s
`define SHORT_START_DEFAULT    16'h0000      // 0.00 s
`define SHORT_STOP_DEFAULT     16'h0032      // 0.50 s
`define SHORT_TIME_MAX         16'h09F6      // 25.50 s
`define FLUX_PCT_DEFAULT       16'h0000      // 0 percent
`define FLUX_PCT_MAX           16'h03E8      // 1000 percent
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_HZ                 25000000      // mclk_in rate
`define TICK_MS                10            // timer resolution in ms
`define TICK_CYCLES            (`CLK_HZ / 1000 * `TICK_MS)
`endif

// File: brake_search_pkg.sv
package brake_search_pkg;
    // ------------------------------------------------------------------------
    // control method and sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        VF_MODE                  = 2'b00,
        OPEN_LOOP_VECTOR_MODE    = 2'b10,
        MAGNET_MOTOR_VECTOR_MODE = 2'b11
    } control_mode_e;
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_WAIT      = 4'b0001,
        ST_INJ_START = 4'b0010,
        ST_SHORT_ST  = 4'b0011,
        ST_EMF_EST   = 4'b0100,
        ST_INJECT    = 4'b0101,
        ST_DETECT    = 4'b0110,
        ST_RECOVER   = 4'b0111,
        ST_RUN       = 4'b1000,
        ST_INJ_STOP  = 4'b1001,
        ST_SHORT_SP  = 4'b1010,
        ST_COAST     = 4'b1011
    } seq_state_e;
    // ------------------------------------------------------------------------
    // outputs to power stage and ramp generator
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        baseblock;       // output off
        logic        dc_inject;       // dc injection active
        logic        phase_short;     // three phases shorted
        logic        flux_boost;      // start flux boost active
        logic [15:0] flux_pct;        // boost level
        logic [7:0]  inj_pct;         // injection current level
        logic        carrier_low;     // force 1 kHz carrier
        logic        search_active;   // speed search running
        logic        search_inject;   // search by current injection
        logic        search_emf;      // search by back emf
        logic        search_detect;   // current-detection search
        logic        freq_lower;      // ramp generator: lower frequency
        logic        volt_recover;    // raise voltage with recovery constant
        logic        ramp_to_ref;     // ramp to frequency reference
        logic        ramp_enable;     // normal ramp operation
    } drive_cmd_s;
endpackage

// File: motor_brake_and_speed_search_seq.sv
`include "brake_search_map.svh"
module motor_brake_and_speed_search_seq #(
    parameter int TICK_CYCLES = `TICK_CYCLES            // cycles per 10 ms tick
) (
    input  wire logic                           mclk_in,                 // 25 MHz clock
    input  wire logic                           reset_n_in,              // async reset, low
    input  wire logic                           run_cmd_in,              // run command
    input  wire logic                           ext_search_in,           // external search
    input  wire logic                           power_ok_in,             // supply present
    input  wire logic                           current_over_in,         // current > threshold
    input  wire logic                           emf_found_in,            // estimate done
    input  wire logic                           recover_done_in,         // voltage recovered
    input  wire logic [15:0]                    out_freq_in,             // 0.1 Hz units
    input  wire logic [15:0]                    brake_start_freq_in,     // 0.1 Hz units
    input  wire logic [15:0]                    min_output_freq_in,      // 0.1 Hz units
    input  wire logic [7:0]                     injection_current_pct_in,// percent
    input  wire logic [15:0]                    injection_time_at_start_in, // 10 ms
    input  wire logic [15:0]                    injection_time_at_stop_in,  // 10 ms
    input  wire logic [15:0]                    flux_boost_pct_in,       // percent
    input  wire logic [15:0]                    phase_short_time_at_start_in, // 10 ms
    input  wire logic [15:0]                    phase_short_time_at_stop_in,  // 10 ms
    input  wire logic [1:0]                     stopping_method_sel_in,  // stop method
    input  wire logic [1:0]                     control_method_sel_in,   // control mode
    input  wire logic                           search_at_start_en_in,   // search each run
    input  wire logic                           search_type_sel_in,      // 1 estimate, 0 detect
    input  wire logic [15:0]                    min_baseblock_time_in,   // 10 ms
    input  wire logic [15:0]                    search_delay_time_in,    // 10 ms
    output brake_search_pkg::drive_cmd_s        cmd_out,                 // drive commands
    output logic [7:0]                          carrier_khz_cap_out,     // carrier cap, 0 none
    output logic [3:0]                          state_out                // sequencer state
);
    // ------------------------------------------------------------------------
    // input synchronisers for pin-level signals
    // ------------------------------------------------------------------------
    logic [3:0] sync1_q;                                        // first stage
    logic [3:0] sync2_q;                                        // second stage
    logic       run_s;                                          // synced run
    logic       ext_s;                                          // synced ext search
    logic       pwr_s;                                          // synced supply
    logic       cur_s;                                          // synced current flag
    // two flip-flops per pin input
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end
        else
        begin
            sync1_q <= {current_over_in, power_ok_in, ext_search_in, run_cmd_in};
            sync2_q <= sync1_q;
        end
    end
    assign run_s = sync2_q[0];
    assign ext_s = sync2_q[1];
    assign pwr_s = sync2_q[2];
    assign cur_s = sync2_q[3];
    // ------------------------------------------------------------------------
    // 10 ms tick divider
    // ------------------------------------------------------------------------
    logic [31:0] div_q;                                         // divider count
    logic [31:0] div_d;                                         // next count
    logic        tick;                                          // 10 ms enable
    // divider next value
    always_comb
    begin
        tick  = (div_q == 32'(TICK_CYCLES - 1));
        div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
    end
    // divider register
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            div_q <= 32'h0000_0000;
        else
            div_q <= div_d;
    end
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // larger of two 16-bit values
    function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
        max16 = (a > b) ? a : b;
    endfunction
    logic        magnet_mode;                                   // shorting mode
    logic [15:0] stop_freq;                                     // effective brake freq
    logic [15:0] wait_time;                                     // search wait
    logic [7:0]  inj_pct;                                       // clamped current
    assign magnet_mode = (control_method_sel_in ==
                          brake_search_pkg::MAGNET_MOTOR_VECTOR_MODE);
    assign stop_freq   = max16(brake_start_freq_in, min_output_freq_in);
    assign wait_time   = max16(min_baseblock_time_in, search_delay_time_in);
    assign inj_pct     = (injection_current_pct_in > `INJ_PCT_MAX) ?
                         `INJ_PCT_MAX : injection_current_pct_in;
    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    brake_search_pkg::seq_state_e st_q;                         // state
    brake_search_pkg::seq_state_e st_d;                         // next state
    logic [15:0] tmr_q;                                         // tick timer
    logic [15:0] tmr_d;                                         // next timer
    logic        run_q;                                         // last run level
    logic        emf_q;                                         // search by emf pending
    logic        emf_d;                                         // next emf flag
    logic        pwr_q;                                         // last supply level
    logic        tmr_zero;                                      // timer expired
    assign tmr_zero = (tmr_q == 16'h0000);
    // next-state logic
    always_comb
    begin
        st_d  = st_q;
        tmr_d = (tick && !tmr_zero) ? tmr_q - 16'h0001 : tmr_q;
        emf_d = emf_q;
        unique case (st_q)
            brake_search_pkg::ST_IDLE:
            begin
                if (run_s && pwr_s && !run_q)
                begin
                    // fresh start: start braking if its time is non-zero, then optional search
                    emf_d = 1'b0;
                    if (magnet_mode && phase_short_time_at_start_in != 16'h0000)
                    begin
                        st_d  = brake_search_pkg::ST_SHORT_ST;
                        tmr_d = phase_short_time_at_start_in;
                    end
                    else if (!magnet_mode && injection_time_at_start_in != 16'h0000)
                    begin
                        st_d  = brake_search_pkg::ST_INJ_START;
                        tmr_d = injection_time_at_start_in;
                    end
                    else if (search_at_start_en_in || ext_s)
                    begin
                        st_d  = brake_search_pkg::ST_WAIT;
                        tmr_d = wait_time;
                    end
                    else
                        st_d  = brake_search_pkg::ST_RUN;
                end
            end
            brake_search_pkg::ST_INJ_START,
            brake_search_pkg::ST_SHORT_ST:
            begin
                if (!run_s)
                    st_d = brake_search_pkg::ST_IDLE;
                else if (tmr_zero)
                begin
                    if (search_at_start_en_in || ext_s)
                    begin
                        st_d  = brake_search_pkg::ST_WAIT;
                        tmr_d = wait_time;
                    end
                    else
                        st_d = brake_search_pkg::ST_RUN;
                end
            end
            brake_search_pkg::ST_WAIT:
            begin
                if (!pwr_s)
                    tmr_d = search_delay_time_in;
                else if (!run_s)
                    st_d = brake_search_pkg::ST_IDLE;
                else if (tmr_zero)
                begin
                    if (search_type_sel_in == `SEARCH_DETECT)
                        st_d = brake_search_pkg::ST_DETECT;
                    else if (emf_q)
                        st_d = brake_search_pkg::ST_EMF_EST;
                    else
                        st_d = brake_search_pkg::ST_INJECT;
                end
            end
            brake_search_pkg::ST_EMF_EST:
            begin
                if (!run_s || !pwr_s)
                    st_d = brake_search_pkg::ST_COAST;
                else if (emf_found_in)
                    st_d = brake_search_pkg::ST_RECOVER;
            end
            brake_search_pkg::ST_INJECT,
            brake_search_pkg::ST_DETECT:
            begin
                if (!run_s || !pwr_s)
                    st_d = brake_search_pkg::ST_COAST;
                else if (!cur_s)
                    st_d = (st_q == brake_search_pkg::ST_INJECT) ? brake_search_pkg::ST_RECOVER :
                           brake_search_pkg::ST_RUN;
            end
            brake_search_pkg::ST_RECOVER:
            begin
                if (!run_s || !pwr_s)
                    st_d = brake_search_pkg::ST_COAST;
                else if (recover_done_in)
                    st_d = brake_search_pkg::ST_RUN;
            end
            brake_search_pkg::ST_RUN:
            begin
                if (!pwr_s)
                begin
                    // short baseblock: back emf is still present
                    st_d  = brake_search_pkg::ST_COAST;
                    tmr_d = 16'h0000;
                end
                else if (!run_s)
                begin
                    if (stopping_method_sel_in != `STOP_RAMP)
                    begin
                        st_d  = brake_search_pkg::ST_COAST;
                        tmr_d = 16'h0000;
                    end
                    else if (out_freq_in < stop_freq)
                    begin
                        st_d  = magnet_mode ? brake_search_pkg::ST_SHORT_SP :
                                brake_search_pkg::ST_INJ_STOP;
                        tmr_d = magnet_mode ? phase_short_time_at_stop_in :
                                injection_time_at_stop_in;
                    end
                end
            end
            brake_search_pkg::ST_INJ_STOP,
            brake_search_pkg::ST_SHORT_SP:
            begin
                if (tmr_zero)
                    st_d = brake_search_pkg::ST_IDLE;
            end
            brake_search_pkg::ST_COAST:
            begin
                // count baseblock; a long one loses back emf
                if (tick && tmr_q != 16'hFFFF)
                    tmr_d = tmr_q + 16'h0001;
                if (pwr_s && !pwr_q && tmr_q > min_baseblock_time_in)
                    tmr_d = 16'h0000;
                if (pwr_s && run_s)
                begin
                    emf_d = (tmr_q <= min_baseblock_time_in);
                    st_d  = brake_search_pkg::ST_WAIT;
                    tmr_d = (tmr_q <= min_baseblock_time_in) ?
                            search_delay_time_in : wait_time;
                end
                else if (tmr_q > min_baseblock_time_in && !run_s)
                    st_d = brake_search_pkg::ST_IDLE;
            end
            default:
                st_d = brake_search_pkg::ST_IDLE;
        endcase
    end
    // sequencer registers
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_q  <= brake_search_pkg::ST_IDLE;
            tmr_q <= 16'h0000;
            run_q <= 1'b0;
            emf_q <= 1'b0;
            pwr_q <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            tmr_q <= tmr_d;
            run_q <= run_s;
            emf_q <= emf_d;
            pwr_q <= pwr_s;
        end
    end
    // ------------------------------------------------------------------------
    // output register
    // ------------------------------------------------------------------------
    brake_search_pkg::drive_cmd_s cmd_d;                        // next commands
    logic [7:0]                   cap_d;                        // next carrier cap
    // decode state into commands
    always_comb
    begin
        cmd_d               = '0;
        cmd_d.inj_pct       = inj_pct;
        cmd_d.dc_inject     = (st_q == brake_search_pkg::ST_INJ_START) ||
                              (st_q == brake_search_pkg::ST_INJ_STOP);
        cmd_d.phase_short   = (st_q == brake_search_pkg::ST_SHORT_ST) ||
                              (st_q == brake_search_pkg::ST_SHORT_SP);
        cmd_d.carrier_low   = cmd_d.dc_inject &&
                              (inj_pct > `INJ_PCT_CARRIER_LIMIT);
        cmd_d.flux_boost    = (st_q == brake_search_pkg::ST_INJ_START) &&
                              (out_freq_in < min_output_freq_in);
        cmd_d.flux_pct      = (flux_boost_pct_in > `FLUX_PCT_MAX) ?
                              `FLUX_PCT_MAX : flux_boost_pct_in;
        cmd_d.search_emf    = (st_q == brake_search_pkg::ST_EMF_EST);
        cmd_d.search_inject = (st_q == brake_search_pkg::ST_INJECT);
        cmd_d.search_detect = (st_q == brake_search_pkg::ST_DETECT);
        cmd_d.search_active = cmd_d.search_emf || cmd_d.search_inject ||
                              cmd_d.search_detect ||
                              (st_q == brake_search_pkg::ST_RECOVER);
        cmd_d.freq_lower    = (cmd_d.search_inject || cmd_d.search_detect) && cur_s;
        cmd_d.volt_recover  = (st_q == brake_search_pkg::ST_RECOVER);
        cmd_d.ramp_to_ref   = (st_q == brake_search_pkg::ST_RUN) && run_s;
        cmd_d.ramp_enable   = (st_q == brake_search_pkg::ST_RUN);
        cmd_d.baseblock     = (st_q == brake_search_pkg::ST_IDLE) ||
                              (st_q == brake_search_pkg::ST_WAIT) ||
                              (st_q == brake_search_pkg::ST_COAST);
        cap_d               = cmd_d.carrier_low ? `CARRIER_LOW_KHZ : 8'h00;
    end
    // register commands
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cmd_out             <= '0;
            carrier_khz_cap_out <= 8'h00;
            state_out           <= 4'h0;
        end
        else
        begin
            cmd_out             <= cmd_d;
            carrier_khz_cap_out <= cap_d;
            state_out           <= st_q;
        end
    end
endmodule // motor_brake_and_speed_search_seq

// File: drive_stage_model.sv
// ----------------------------------------------------------------------------
// power stage and ramp generator stand-in
// ----------------------------------------------------------------------------
module drive_stage_model (
    input  wire logic                   mclk_in,          // control clock
    input  brake_search_pkg::drive_cmd_s cmd_in,          // sequencer commands
    output logic                        emf_found_out,    // estimate settled
    output logic                        recover_done_out, // voltage restored
    output logic                        current_over_out  // slip current high
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] ph_q = 4'h0;  // search phase seen last cycle
    logic [7:0] n_q = 8'h00;  // cycles spent in that phase
    logic [3:0] ph;
    logic [7:0] age;
    assign ph = {cmd_in.search_emf, cmd_in.search_inject, cmd_in.search_detect, cmd_in.volt_recover};
    assign age = (ph != ph_q) ? 8'h00 : n_q;
    // age restarts whenever the search phase changes
    always_ff @(posedge mclk_in)
    begin
        ph_q <= ph;
        n_q  <= age + 8'h01;
    end
    assign emf_found_out    = cmd_in.search_emf && age > 8'h05;
    assign recover_done_out = cmd_in.volt_recover && age > 8'h05;
    assign current_over_out = !((cmd_in.search_inject || cmd_in.search_detect) && age > 8'h05);
endmodule // drive_stage_model

// File: brake_seq_checker.sv
// ----------------------------------------------------------------------------
// port checker
// ----------------------------------------------------------------------------
module brake_seq_checker #(
    parameter int TICK_CYCLES = 250000
) (
    input  wire logic                    mclk_in,
    input  wire logic                    reset_n_in,
    input  wire logic [7:0]              injection_current_pct_in,
    input  wire logic [15:0]             injection_time_at_start_in,
    input  wire logic [1:0]              stopping_method_sel_in,
    input  wire logic [1:0]              control_method_sel_in,
    input  wire logic                    search_type_sel_in,
    input  brake_search_pkg::drive_cmd_s cmd_out,
    input  wire logic [7:0]              carrier_khz_cap_out,
    input  wire logic [3:0]              state_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] n_q, n_d;  // cycles spent in start injection
    always_comb n_d = (state_out == brake_search_pkg::ST_INJ_START) ? n_q + 32'h0000_0001 : '0;
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in) n_q <= '0;
        else n_q <= n_d;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence inj_end;
        $fell(state_out == brake_search_pkg::ST_INJ_START);
    endsequence
    chk_inj_level: assert property (cmd_out.dc_inject |-> cmd_out.inj_pct <= 8'h4B
        && cmd_out.inj_pct <= injection_current_pct_in) else $error("injection level");
    chk_carrier_cap: assert property ($rose(cmd_out.dc_inject) && cmd_out.inj_pct > 8'h32
        |-> ##[0:1] carrier_khz_cap_out == 8'h01) else $error("carrier not capped");
    chk_start_time: assert property (inj_end |-> n_q + TICK_CYCLES >=
        injection_time_at_start_in * TICK_CYCLES && n_q <= (injection_time_at_start_in + 1)
        * TICK_CYCLES) else $error("start injection length");
    chk_inj_mode: assert property (cmd_out.dc_inject |-> control_method_sel_in != 2'h3)
        else $error("injection in magnet mode");
    chk_short_mode: assert property (cmd_out.phase_short |-> control_method_sel_in == 2'h3)
        else $error("shorting outside magnet mode");
    chk_stop_ramp: assert property (state_out inside {4'h9, 4'hA} |->
        stopping_method_sel_in == 2'h0) else $error("stop brake without ramp stop");
    chk_detect_sel: assert property (cmd_out.search_detect |-> !search_type_sel_in)
        else $error("detect search with estimate selected");
    chk_estimate_sel: assert property (cmd_out.search_emf || cmd_out.search_inject
        |-> search_type_sel_in) else $error("estimate search with detect selected");
endmodule // brake_seq_checker

// File: tb_motor_brake_and_speed_search_seq.sv
module tb_motor_brake_and_speed_search_seq;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in, reset_n_in = 1'b0, run_cmd_in = 1'b0, ext_search_in = 1'b0, power_ok_in = 1'b1;
    logic search_at_start_en_in = 1'b0, search_type_sel_in = 1'b1;
    logic current_over_in, emf_found_in, recover_done_in;
    logic [15:0] out_freq_in = 16'h0064, brake_start_freq_in = 16'h0005, min_output_freq_in = 16'h0002;
    logic [15:0] injection_time_at_start_in = 16'h0003, injection_time_at_stop_in = 16'h0002;
    logic [15:0] phase_short_time_at_start_in = 16'h0002, phase_short_time_at_stop_in = 16'h0002;
    logic [15:0] flux_boost_pct_in = 16'h0064, min_baseblock_time_in = 16'h0005;
    logic [15:0] search_delay_time_in = 16'h0008;
    logic [7:0] injection_current_pct_in = 8'h3C, carrier_khz_cap_out;
    logic [1:0] stopping_method_sel_in = 2'h0, control_method_sel_in = 2'h0;
    logic [3:0] state_out;
    brake_search_pkg::drive_cmd_s cmd_out;
    int fail_count = 0, check_count = 0;
    motor_brake_and_speed_search_seq #(.TICK_CYCLES(10)) motor_brake_and_speed_search_seq_i (.*);
    drive_stage_model drive_stage_model_i (.mclk_in(mclk_in), .cmd_in(cmd_out),
        .emf_found_out(emf_found_in), .recover_done_out(recover_done_in),
        .current_over_out(current_over_in));
    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic check(input bit ok, input string m);
        check_count++;
        if (!ok)
        begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wait_st(input logic [3:0] s);
        int n = 0;
        while (state_out !== s && n < 3000)
        begin
            @(negedge mclk_in);
            n++;
        end
        check(state_out === s, "state not reached");
    endtask
    // start with braking, then stop by the chosen method; a ramp stop brakes at frequency f
    task automatic brk(input logic [1:0] m, sm, input logic [7:0] p, input logic [15:0] f);
        control_method_sel_in = m;
        stopping_method_sel_in = sm;
        injection_current_pct_in = p;
        out_freq_in = 16'h0000;
        run_cmd_in = 1'b1;
        wait_st(m == 2'h3 ? 4'h3 : 4'h2);
        repeat (2) @(negedge mclk_in);
        if (m != 2'h3)
        begin
            check(cmd_out.inj_pct === (p > 8'h4B ? 8'h4B : p), "inj level");
            check(carrier_khz_cap_out === (p > 8'h32 ? 8'h01 : 8'h00), "cap");
            check(cmd_out.flux_boost === 1'b1 && cmd_out.flux_pct === 16'h0064, "boost");
        end
        else
            check(cmd_out.phase_short === 1'b1 && cmd_out.dc_inject === 1'b0, "no short");
        wait_st(4'h8);
        check(cmd_out.ramp_to_ref === 1'b1 && cmd_out.baseblock === 1'b0, "not running");
        out_freq_in = f + 16'h0003;
        run_cmd_in = 1'b0;
        repeat (20) @(negedge mclk_in);
        if (sm == 2'h0) check(state_out === 4'h8, "braked too early");
        out_freq_in = f;
        wait_st(sm != 2'h0 ? 4'hB : m == 2'h3 ? 4'hA : 4'h9);
        wait_st(4'h0);
        $display("brake test done");
    endtask
    task automatic srch(input logic sel);
        int n = 0;
        search_type_sel_in = sel;
        search_at_start_en_in = sel;
        ext_search_in = !sel;
        run_cmd_in = 1'b1;
        wait_st(4'h1);
        while (state_out === 4'h1)
        begin
            @(negedge mclk_in);
            n++;
        end
        check(n >= 70, "search wait short");
        wait_st(sel ? 4'h5 : 4'h6);
        check(cmd_out.freq_lower === 1'b1, "no frequency lowering");
        wait_st(4'h8);
        run_cmd_in = 1'b0;
        wait_st(4'h0);
        $display("search test done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge mclk_in);
        reset_n_in = 1'b1;
        brk(2'h0, 2'h0, 8'h3C, 16'h0003);
        min_output_freq_in = 16'h0008;
        brk(2'h2, 2'h0, 8'h5A, 16'h0006);
        brk(2'h3, 2'h0, 8'h3C, 16'h0006);
        brk(2'h0, 2'h1, 8'h28, 16'h0003);
        control_method_sel_in = 2'h0;
        injection_time_at_start_in = 16'h0000;
        srch(1'b1);
        srch(1'b0);
        search_at_start_en_in = 1'b0;
        ext_search_in = 1'b0;
        search_type_sel_in = 1'b1;
        run_cmd_in = 1'b1;
        wait_st(4'h8);
        power_ok_in = 1'b0;
        repeat (5) @(negedge mclk_in);
        power_ok_in = 1'b1;
        wait_st(4'h4);
        wait_st(4'h7);
        check(cmd_out.volt_recover === 1'b1, "no voltage recovery");
        wait_st(4'h8);
        run_cmd_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        run_cmd_in = 1'b1;
        wait_st(4'h4);
        $display("power loss test done");
        final_report;
    end
    initial
    begin
        repeat (40000) @(posedge mclk_in);
        fail_count++;
        final_report;
    end
endmodule // tb_motor_brake_and_speed_search_seq
bind motor_brake_and_speed_search_seq brake_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.*);
